// >>> rtl/sahcp_regs.vh
// Constants for the converter control port: APB offsets, fields, reset values, timing.
// Assumes a 10 MHz system clock; included by bare name from the rtl files.
`ifndef SAHCP_REGS_VH
`define SAHCP_REGS_VH

// ==========================================
// Register offsets (byte addresses)
`define SAHCP_CTRL_OFF 12'h000
`define SAHCP_STAT_OFF 12'h004
`define SAHCP_RSLT_OFF 12'h008
`define SAHCP_COMP_OFF 12'h00C

// ==========================================
// Control register fields
`define SAHCP_CTRL_SW_EN 0
`define SAHCP_CTRL_FULL 1
`define SAHCP_CTRL_RST 32'h0000_0000

// ==========================================
// Status register fields
`define SAHCP_STAT_BUSY 0
`define SAHCP_STAT_SHORT 1
`define SAHCP_STAT_OE 2
`define SAHCP_STAT_DONE 3

// ==========================================
// Timing
`define SAHCP_CLK_HZ 10000000
`define SAHCP_STEP_NS 100
`define SAHCP_STEP_CYC ((`SAHCP_STEP_NS * (`SAHCP_CLK_HZ / 1000000)) / 1000)
`define SAHCP_RES_BITS 12
`define SAHCP_SHORT_BITS 8

`endif

// >>> rtl/sahcp_sync.v
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the inputs come from outside sys_clk; stage one feeds only stage two.
`timescale 1ns/1ps
module sahcp_sync #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	input wire clk_en,
	// Levels
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // sahcp_sync

// >>> rtl/sahcp_sar.v
// Successive-approximation sequencer: one result bit per step, MSB first.
// Assumes comp_in is already synchronous to sys_clk.
`timescale 1ns/1ps
`include "sahcp_regs.vh"
module sahcp_sar #(
	parameter NBITS = `SAHCP_RES_BITS,
	parameter STEP_CYC = `SAHCP_STEP_CYC
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	input wire clk_en,
	// Control
	input wire start,
	input wire short_len,
	input wire comp_in,
	// Outputs
	output reg [NBITS-1:0] trial_q,
	output reg [NBITS-1:0] result_q,
	output reg running_q,
	output reg done_q
);
	reg [3:0] bit_q;
	reg [7:0] tick_q;
	wire [3:0] last_bit;
	wire [NBITS-1:0] one_hot;

	localparam [31:0] TOP_BIT = NBITS - 1;
	localparam [31:0] SHORT_STOP = NBITS - `SAHCP_SHORT_BITS;
	localparam [31:0] STEP_LAST = STEP_CYC - 1;
	wire [NBITS-1:0] short_mask;

	// Stop point follows the current length so a recapture can change it
	assign last_bit = short_len ? SHORT_STOP[3:0] : 4'h0;
	// A late switch to short length must still clear the low bits
	assign short_mask = short_len ? ({NBITS{1'b1}} << SHORT_STOP) : {NBITS{1'b1}};
	assign one_hot = {{(NBITS-1){1'b0}}, 1'b1} << bit_q;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trial_q <= {NBITS{1'b0}};
			result_q <= {NBITS{1'b0}};
			running_q <= 1'b0;
			done_q <= 1'b0;
			bit_q <= 4'h0;
			tick_q <= 8'h00;
		end else if (clk_en) begin
			done_q <= 1'b0;
			if (start && !running_q) begin
				running_q <= 1'b1;
				bit_q <= TOP_BIT[3:0];
				trial_q <= {1'b1, {(NBITS-1){1'b0}}};
				tick_q <= 8'h00;
			end else if (running_q) begin
				if (tick_q == STEP_LAST[7:0]) begin
					tick_q <= 8'h00;
					// Keep or drop the trial bit, then try the next
					// A recapture after the stop bit has passed ends the run here
					if (bit_q <= last_bit) begin
						// Unresolved low bits read as zero after a short run
						result_q <= (comp_in ? trial_q : (trial_q & ~one_hot))
							& ~(one_hot - {{(NBITS-1){1'b0}}, 1'b1}) & short_mask;
						running_q <= 1'b0;
						done_q <= 1'b1;
					end else begin
						trial_q <= (comp_in ? trial_q : (trial_q & ~one_hot))
							| (one_hot >> 1);
						bit_q <= bit_q - 4'h1;
					end
				end else begin
					tick_q <= tick_q + 8'h01;
				end
			end
		end
	end
endmodule // sahcp_sar

// >>> rtl/sahcp_top.v
// Control and read-out port of a 12-bit successive-approximation converter.
// Assumes asynchronous host pins and an APB master on sys_clk.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "sahcp_regs.vh"
module sahcp_top #(
	parameter NBITS = `SAHCP_RES_BITS,
	parameter STEP_CYC = `SAHCP_STEP_CYC
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	input wire clk_en,
	// Host control pins
	input wire chip_enable_hi,
	input wire select_low_in_n,
	input wire read_convert_sel,
	input wire byte_addr_short,
	input wire word_width_sel,
	// Comparator decision from the analog array
	input wire comp_in,
	// Three-state result pins, busy output and trial word to the comparator
	output reg [NBITS-1:0] result_bits_o,
	output reg [NBITS-1:0] result_bits_oe,
	output wire busy_o,
	output wire [NBITS-1:0] trial_o,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr
);
	// ==========================================
	// Pin synchronisers
	// The comparator answers trial_o, a register of this clock, within one step,
	// so it skips the synchroniser: two flops would make each decision stale
	wire [4:0] pin_s;

	sahcp_sync #(
		.WIDTH(5)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.async_in({word_width_sel, byte_addr_short, read_convert_sel, select_low_in_n,
			chip_enable_hi}),
		.sync_out(pin_s)
	);

	wire ce_s = pin_s[0];
	wire cs_n_s = pin_s[1];
	wire rc_s = pin_s[2];
	wire addr_short_s = pin_s[3];
	wire w12_s = pin_s[4];

	// ==========================================
	// Registers
	reg [1:0] ctrl_q;
	reg [1:0] sw_start_q;
	reg start_cond_q;
	reg short_q;
	reg done_seen_q;
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd_ok;

	// ==========================================
	// Start detection
	// A combined level means simultaneous changes give the same delay
	wire start_cond = ce_s && !cs_n_s && !rc_s;
	wire start_edge = start_cond && !start_cond_q;
	wire sw_start = ctrl_q[`SAHCP_CTRL_SW_EN] && sw_start_q[0];
	wire run;
	wire done;
	wire [NBITS-1:0] result;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_cond_q <= 1'b0;
			short_q <= 1'b0;
			done_seen_q <= 1'b0;
		end else if (clk_en) begin
			start_cond_q <= start_cond;
			// Recapture even while busy, so length can change mid-run
			if (start_edge || sw_start)
				short_q <= addr_short_s;
			if (done)
				done_seen_q <= 1'b1;
			else if (start_edge && !run)
				done_seen_q <= 1'b0;
		end
	end

	// Busy sequencer ignores starts while running
	sahcp_sar #(
		.NBITS(NBITS),
		.STEP_CYC(STEP_CYC)
	) u_sar (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.start(start_edge || sw_start),
		.short_len(start_edge ? addr_short_s : short_q),
		.comp_in(comp_in),
		.trial_q(trial_o),
		.result_q(result),
		.running_q(run),
		.done_q(done)
	);

	// Busy covers the done cycle, in which the result is latched, so it falls
	// only once the result stands and no gap opens between run and done
	assign busy_o = run || done;

	// ==========================================
	// Output drivers
	wire read_ok = rc_s && !busy_o && ce_s && !cs_n_s;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_bits_o <= {NBITS{1'b0}};
			result_bits_oe <= {NBITS{1'b0}};
		end else if (clk_en) begin
			if (!read_ok) begin
				result_bits_oe <= {NBITS{1'b0}};
			end else if (w12_s) begin
				result_bits_o <= result;
				result_bits_oe <= {NBITS{1'b1}};
			end else if (!addr_short_s) begin
				// 8 MSBs on the upper lines
				result_bits_o <= {result[11:4], 4'h0};
				result_bits_oe <= {{8{1'b1}}, 4'h0};
			end else begin
				// 4 LSBs left-justified then four zeros
				result_bits_o <= {result[3:0], 4'h0, 4'h0};
				result_bits_oe <= {{8{1'b1}}, 4'h0};
			end
		end
	end

	// ==========================================
	// APB slave
	assign pready = 1'b1;
	assign apb_rd_ok = (paddr == `SAHCP_CTRL_OFF) || (paddr == `SAHCP_STAT_OFF) ||
		(paddr == `SAHCP_RSLT_OFF) || (paddr == `SAHCP_COMP_OFF);
	assign pslverr = psel && penable && !apb_rd_ok;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= 2'b00;
			sw_start_q <= 2'b00;
		end else if (clk_en) begin
			sw_start_q <= 2'b00;
			if (apb_wr && paddr == `SAHCP_CTRL_OFF)
				ctrl_q <= pwdata[1:0];
			// Software start pulse, only while the pins hold the start levels
			if (apb_wr && paddr == `SAHCP_COMP_OFF)
				sw_start_q <= {1'b0, pwdata[0] && ce_s && !cs_n_s && !rc_s};
		end
	end

	always @* begin
		prdata = 32'h0000_0000;
		if (paddr == `SAHCP_CTRL_OFF)
			prdata = {30'h0000_0000, ctrl_q};
		else if (paddr == `SAHCP_STAT_OFF)
			prdata = {28'h000_0000, done_seen_q, |result_bits_oe, short_q, busy_o};
		else if (paddr == `SAHCP_RSLT_OFF)
			prdata = {20'h0_0000, result};
	end
endmodule // sahcp_top

// >>> testbench/sahcp_top_checker.sv
// Pin checker for the converter port.
// Assumes pins change on sys_clk edges, two-flop pin sync, one cycle a step.
`timescale 1ns/1ps
module sahcp_chk #(
	parameter NBITS = 12
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Pins
	input wire chip_enable_hi,
	input wire select_low_in_n,
	input wire read_convert_sel,
	input wire word_width_sel,
	input wire busy_o,
	input wire [NBITS-1:0] result_bits_oe
);
	wire rd = chip_enable_hi & !select_low_in_n & read_convert_sel;
	wire st = chip_enable_hi & !select_low_in_n & !read_convert_sel;
	wire [11:0] oe = result_bits_oe;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Pin assertions
	property p_float; busy_o |-> oe == 12'h000; endproperty
	a_float: assert property (p_float) else $error("driven while busy");
	property p_min; $rose(busy_o) |-> busy_o [*8]; endproperty
	a_min: assert property (p_min) else $error("busy short");
	property p_max; $rose(busy_o) |-> ##[8:13] !busy_o; endproperty
	a_max: assert property (p_max) else $error("busy long");
	property p_start; $rose(st) && !busy_o |-> ##[2:4] busy_o; endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_cause; $rose(busy_o) |-> $past(st, 2) || $past(st, 3) || $past(st, 4); endproperty
	a_cause: assert property (p_cause) else $error("stray start");
	property p_en; |oe |-> $past(rd, 2) || $past(rd, 3) || $past(rd, 4); endproperty
	a_en: assert property (p_en) else $error("stray drive");
	property p_word; oe == 12'hfff |-> $past(word_width_sel, 3); endproperty
	a_word: assert property (p_word) else $error("bad word");
	property p_byte; oe == 12'hff0 |-> !$past(word_width_sel, 3); endproperty
	a_byte: assert property (p_byte) else $error("bad byte");
	property p_late; $fell(busy_o) |-> oe == 12'h000; endproperty
	a_late: assert property (p_late) else $error("early drive");
	c_conv: cover property ($rose(busy_o));
	c_word: cover property (oe == 12'hfff);
	c_byte: cover property (oe == 12'hff0);
endmodule // sahcp_chk
bind sahcp_top sahcp_chk #(.NBITS(NBITS)) u_chk (.sys_clk, .rst_n, .chip_enable_hi,
	.select_low_in_n, .read_convert_sel, .word_width_sel, .busy_o, .result_bits_oe);

// >>> testbench/sahcp_comp_model.sv
// Comparator stand-in for the analog array.
// Assumes trial_o carries the bit under test already set.
`timescale 1ns/1ps
module sahcp_comp_model (
	// Trial and held level
	input wire [11:0] trial_o,
	input wire [11:0] level,
	// Decision
	output wire comp_in
);
	assign comp_in = (trial_o <= level);
endmodule // sahcp_comp_model

// >>> testbench/tb_sar_adc_host_control_port.sv
// Bench for the converter port: pin and APB tasks.
// Assumes the comparator model answers at once.
`timescale 1ns/1ps
module tb_sar_adc_host_control_port;
	logic sys_clk = 0, rst_n = 0, clk_en = 1, chip_enable_hi = 1, select_low_in_n = 0;
	logic read_convert_sel = 1, byte_addr_short = 0, word_width_sel = 1, comp_in, er;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, busy_o;
	logic [11:0] paddr = 12'h000, result_bits_o, result_bits_oe, trial_o, level = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	int n_mismatch = 0, tests_run = 0;
	sahcp_top dut (.sys_clk, .rst_n, .clk_en, .chip_enable_hi, .select_low_in_n,
		.read_convert_sel, .byte_addr_short, .word_width_sel, .comp_in, .result_bits_o,
		.result_bits_oe, .busy_o, .trial_o, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	sahcp_comp_model cmp (.trial_o, .level, .comp_in);
	always #50 sys_clk = ~sys_clk;
	// ==========================================
	// Tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input [31:0] e, input [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wait_busy(input logic v);
		for (int i = 0; i < 30 && busy_o !== v; i++) cyc(1);
		chk("busy", v, busy_o);
	endtask
	// One edge before setup keeps psel from being assigned twice in a step
	task automatic apb(input logic w, input [11:0] a, input [31:0] wd, input [31:0] e, input logic ee);
		cyc(1);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		cyc(1);
		penable <= 1;
		cyc(1);
		while (pready !== 1'b1) cyc(1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (!w) chk("prdata", e, rd);
		chk("pslverr", ee, er);
	endtask
	// Start pulse, then a second start while busy that must not restart
	task automatic conv(input [11:0] lv, input logic len_first, input logic len_mid);
		logic [11:0] e;
		e = len_mid ? {lv[11:4], 4'h0} : lv;
		level <= lv;
		byte_addr_short <= len_first;
		cyc(1);
		read_convert_sel <= 0;
		cyc(1);
		read_convert_sel <= 1;
		wait_busy(1);
		chk("trial", 12'h800, trial_o);
		byte_addr_short <= len_mid;
		read_convert_sel <= 0;
		cyc(1);
		read_convert_sel <= 1;
		wait_busy(0);
		cyc(4);
		chk("word", {e, 12'hfff}, {result_bits_o, result_bits_oe});
		word_width_sel <= 0;
		byte_addr_short <= 0;
		cyc(5);
		chk("hi", {e[11:4], 12'hff0}, {result_bits_o[11:4], result_bits_oe});
		byte_addr_short <= 1;
		cyc(5);
		chk("lo", {e[3:0], 4'h0}, result_bits_o[11:4]);
		word_width_sel <= 1;
		byte_addr_short <= 0;
		cyc(4);
	endtask
	// ==========================================
	// Sequence
	initial begin
		cyc(4);
		rst_n <= 1;
		cyc(1);
		chk("rst", 0, {busy_o, result_bits_oe});
		chk("trial_rst", 0, trial_o);
		apb(0, 12'h000, 0, 0, 0);
		apb(1, 12'h000, 1, 0, 0);
		apb(0, 12'h000, 0, 1, 0);
		apb(1, 12'h00C, 1, 0, 0);
		cyc(4);
		chk("sw_rc", 0, busy_o);
		conv(12'ha5c, 0, 0);
		conv(12'h3c7, 1, 1);
		conv(12'h9e3, 0, 1);
		conv(12'hfff, 1, 0);
		conv(12'h000, 0, 0);
		level <= 12'h5a5;
		read_convert_sel <= 0;
		wait_busy(1);
		wait_busy(0);
		cyc(4);
		chk("oe_low", 0, result_bits_oe);
		for (int i = 0; i < 2; i++) begin
			read_convert_sel <= 1;
			cyc(4);
			chip_enable_hi <= i;
			select_low_in_n <= i;
			read_convert_sel <= 0;
			cyc(8);
			chk("off", 0, {busy_o, result_bits_oe});
			chip_enable_hi <= 1;
			select_low_in_n <= 0;
			wait_busy(1);
			wait_busy(0);
		end
		read_convert_sel <= 1;
		cyc(4);
		apb(0, 12'h008, 0, 32'h0000_05a5, 0);
		apb(0, 12'h004, 0, 32'h0000_000c, 0);
		apb(0, 12'h010, 0, 0, 1);
		report_and_stop;
	end
	initial begin
		#300_000;
		n_mismatch++;
		report_and_stop;
	end
endmodule // tb_sar_adc_host_control_port
